// ==== core/tsac_pkg.sv ====
package tsac_pkg;

  // ==========================================================================
  // cc line classification from the analog comparators
  typedef enum logic [1:0] {
    TSAC_CC_OPEN = 2'h0,
    TSAC_CC_RD   = 2'h1,
    TSAC_CC_RA   = 2'h2
  } tsac_cc_t;

  // ==========================================================================
  // advertised current level driven into the cc source current dac
  typedef enum logic [1:0] {
    TSAC_ADV_STD   = 2'h0,
    TSAC_ADV_1A5   = 2'h1,
    TSAC_ADV_3A    = 2'h2
  } tsac_adv_t;

  // ==========================================================================
  // detection inputs carried together
  typedef struct packed {
    tsac_cc_t cc1;
    tsac_cc_t cc2;
  } tsac_det_t;

  // switch controls carried together
  typedef struct packed {
    logic vbus_on;
    logic vconn_cc1;
    logic vconn_cc2;
  } tsac_sw_t;

  // ==========================================================================
  // timing
  localparam int unsigned TSAC_CLK_MHZ       = 125;
  localparam int unsigned TSAC_DEGLITCH_US   = 150;
  localparam int unsigned TSAC_DEGLITCH_CYC  = TSAC_DEGLITCH_US * TSAC_CLK_MHZ;
  localparam int unsigned TSAC_CNT_W         = 16;
  localparam logic [TSAC_CNT_W-1:0] TSAC_CNT_ZERO = 16'h0000;
  localparam logic [TSAC_CNT_W-1:0] TSAC_CNT_ONE  = 16'h0001;

  // reset values
  localparam tsac_det_t TSAC_DET_RST = '{cc1: TSAC_CC_OPEN, cc2: TSAC_CC_OPEN};
  localparam tsac_sw_t  TSAC_SW_OFF  = '{vbus_on: 1'b0, vconn_cc1: 1'b0,
                                         vconn_cc2: 1'b0};

endpackage

// ==== core/tsac_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// three-stage synchroniser; output moves once stages two and three agree
module tsac_sync
  import tsac_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] held;
  logic [W-1:0] next_held;

  // per bit: take stage three where it matches stage two, else hold;
  // a chattering bit must not freeze the other bits of the word
  always_comb begin
    next_held = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & held);
  end

  // three stages and the agreed value
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      held <= '0;
    end else begin
      s1   <= i_async;
      s2   <= s1;
      s3   <= s2;
      held <= next_held;
    end
  end

  assign o_sync = held;

endmodule

`default_nettype wire

// ==== core/tsac_top.sv ====
// Function
// - Drive the test-accessory flag low when Rd is seen on both CC pins.
// - Once a test accessory is flagged, watch only CC1, release on Rd loss.
// - Keep the orientation flag released whenever no sink is attached.
// - With a sink, release orientation for Rd on CC1, drive low for CC2 Rd.
// - With enable low, open both switches, release all flags, stop CC watch.
// - Start only after aux supply is good, then sample enable high to run.
// - Assert the high-load flag low while a sink is attached and load current exceeds 1.95 A.
// - Pull the sink-attached output low while a sink is attached.
// - After start-up keep monitoring CC1 and CC2 for a sink attach.
// - Turn VBUS on only after the attach deglitch time has elapsed.
// - Route VCONN to the CC pin that shows Ra opposite the sink.
// - Remove VBUS as soon as the sink detaches.
// - Advertise current from the live state of the two select inputs.
// - Low select 0 gives standard, 1,0 gives 1.5 A and 1,1 gives 3 A.
`timescale 1ns/1ps
`default_nettype none

module tsac_top
  import tsac_pkg::*;
#(
  parameter int unsigned DEGLITCH_CYC = TSAC_DEGLITCH_CYC
) (
  input  wire logic      i_clk,
  input  wire logic      i_rst_n,
  input  wire logic      i_aux_good,               // aux above uvlo
  input  wire logic      i_enable,                 // system enable pin
  input  wire logic      i_adv_level_sel_lo,
  input  wire logic      i_adv_level_sel_hi,
  input  wire tsac_det_t i_det,                    // cc comparators
  input  wire logic      i_load_over,              // load above 1.95 A cmp
  output tsac_sw_t       o_sw,                     // vbus / vconn switches
  output tsac_adv_t      o_adv,                    // cc current source level
  output logic           o_cc_mon_en,              // cc comparator enable
  output logic           o_plug_orientation_flag_oe,
  output logic           o_test_acc_oe,
  output logic           o_sink_attached_n_oe,
  output logic           o_high_load_oe
);

  // ==========================================================================
  // input synchronisation
  localparam int unsigned SYW = 5 + $bits(tsac_det_t);

  logic [SYW-1:0] sy;
  logic           aux_s;
  logic           en_s;
  logic           sel_lo_s;
  logic           sel_hi_s;
  logic           load_s;
  tsac_det_t      det_s;

  // one three-stage path for every pin-level input
  tsac_sync #(.W(SYW)) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async ({i_aux_good, i_enable, i_adv_level_sel_lo, i_adv_level_sel_hi,
               i_load_over, i_det}),
    .o_sync  (sy)
  );

  // enable is trusted to be a driven level, no float handling
  assign {aux_s, en_s, sel_lo_s, sel_hi_s, load_s, det_s} = sy;

  // ==========================================================================
  // detection state machine
  typedef enum logic [2:0] {
    ST_OFF,
    ST_UNATT,
    ST_DEGL,
    ST_SINK1,
    ST_SINK2,
    ST_TACC
  } tsac_st_t;

  tsac_st_t              st;
  tsac_st_t              next_st;
  tsac_det_t             last_det;
  tsac_det_t             next_last_det;
  logic [TSAC_CNT_W-1:0] cnt;
  logic [TSAC_CNT_W-1:0] next_cnt;

  function automatic logic is_rd(input tsac_cc_t c);
    return c == TSAC_CC_RD;
  endfunction

  // stability load; the parameter must stay below 2**16, a larger value
  // wraps here and would shorten the attach deglitch
  localparam logic [TSAC_CNT_W-1:0] DEGL_LOAD = TSAC_CNT_W'(DEGLITCH_CYC);

  // attach decode and stability count
  always_comb begin
    next_st       = st;
    next_last_det = det_s;
    next_cnt      = cnt;
    if (!aux_s || !en_s) begin
      next_st  = ST_OFF;
      next_cnt = DEGL_LOAD;
    end else begin
      unique case (st)
        ST_OFF: begin
          next_st  = ST_UNATT;
          next_cnt = DEGL_LOAD;
        end
        ST_UNATT: begin
          if (is_rd(det_s.cc1) || is_rd(det_s.cc2)) begin
            next_st  = ST_DEGL;
            next_cnt = DEGL_LOAD;
          end
        end
        ST_DEGL: begin
          // a changed class restarts the count, so a pin that moves
          // from one rd pattern to another is judged afresh
          if (!(is_rd(det_s.cc1) || is_rd(det_s.cc2))) begin
            next_st = ST_UNATT;
          end else if (det_s != last_det) begin
            next_cnt = DEGL_LOAD;
          end else if (cnt > TSAC_CNT_ONE) begin
            next_cnt = cnt - TSAC_CNT_ONE;
          end else if (is_rd(det_s.cc1) && is_rd(det_s.cc2)) begin
            next_st = ST_TACC;
          end else if (is_rd(det_s.cc1)) begin
            next_st = ST_SINK1;
          end else begin
            next_st = ST_SINK2;
          end
        end
        ST_SINK1: begin
          if (!is_rd(det_s.cc1)) begin
            next_st = ST_UNATT;
          end
        end
        ST_SINK2: begin
          if (!is_rd(det_s.cc2)) begin
            next_st = ST_UNATT;
          end
        end
        ST_TACC: begin
          // only cc1 ends the accessory; cc2 may open meanwhile
          if (!is_rd(det_s.cc1)) begin
            next_st = ST_UNATT;
          end
        end
        default: next_st = ST_OFF;
      endcase
    end
  end

  // state, last class and stability count registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st       <= ST_OFF;
      last_det <= TSAC_DET_RST;
      cnt      <= TSAC_CNT_ZERO;
    end else begin
      st       <= next_st;
      last_det <= next_last_det;
      cnt      <= next_cnt;
    end
  end

  // ==========================================================================
  // output decode from the one state plus the live cc, load and select inputs
  // open-drain enables are high while the pin is pulled low
  tsac_sw_t  next_sw;
  tsac_adv_t next_adv;
  logic      next_mon;
  logic      next_pol_oe;
  logic      next_tacc_oe;
  logic      next_sink_oe;
  logic      next_load_oe;
  logic      sink;

  always_comb begin
    sink         = (st == ST_SINK1) || (st == ST_SINK2);
    next_mon     = (st != ST_OFF);
    next_sw      = TSAC_SW_OFF;
    next_sw.vbus_on = sink;
    // vconn to the non-sink pin only when it shows ra
    next_sw.vconn_cc2 = (st == ST_SINK1) &&
                        (det_s.cc2 == TSAC_CC_RA);
    next_sw.vconn_cc1 = (st == ST_SINK2) &&
                        (det_s.cc1 == TSAC_CC_RA);
    next_pol_oe  = (st == ST_SINK2);
    next_tacc_oe = (st == ST_TACC);
    next_sink_oe = sink;
    // no load current flows without vbus, so the flag waits for a sink
    next_load_oe = sink && load_s;
    // selects followed live while running
    if (!sel_lo_s) begin
      next_adv = TSAC_ADV_STD;
    end else if (sel_hi_s) begin
      next_adv = TSAC_ADV_3A;
    end else begin
      next_adv = TSAC_ADV_1A5;
    end
  end

  // every top output straight from a flip-flop
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sw                       <= TSAC_SW_OFF;
      o_adv                      <= TSAC_ADV_STD;
      o_cc_mon_en                <= 1'b0;
      o_plug_orientation_flag_oe <= 1'b0;
      o_test_acc_oe              <= 1'b0;
      o_sink_attached_n_oe       <= 1'b0;
      o_high_load_oe             <= 1'b0;
    end else begin
      o_sw                       <= next_sw;
      o_adv                      <= next_adv;
      o_cc_mon_en                <= next_mon;
      o_plug_orientation_flag_oe <= next_pol_oe;
      o_test_acc_oe              <= next_tacc_oe;
      o_sink_attached_n_oe       <= next_sink_oe;
      o_high_load_oe             <= next_load_oe;
    end
  end

endmodule

`default_nettype wire

// ==== sim/tsac_sink_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// far side on cc: 0 none, 1 sink, 2 reversed sink with cable, 3 test acc
// 4 sink with a marked cable on cc2
module tsac_sink_model
  import tsac_pkg::*;
(
  input  wire logic [2:0] i_mode,
  output var tsac_det_t   o_det
);
  // class seen per pin; an absent party leaves both pins open
  always_comb begin
    case (i_mode)
      3'h1:    o_det = '{cc1: TSAC_CC_RD, cc2: TSAC_CC_OPEN};
      3'h2:    o_det = '{cc1: TSAC_CC_RA, cc2: TSAC_CC_RD};
      3'h3:    o_det = '{cc1: TSAC_CC_RD, cc2: TSAC_CC_RD};
      3'h4:    o_det = '{cc1: TSAC_CC_RD, cc2: TSAC_CC_RA};
      default: o_det = TSAC_DET_RST;
    endcase
  end
endmodule
`default_nettype wire

// ==== sim/tsac_top_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
module tsac_top_monitor
  import tsac_pkg::*;
#(
  parameter int unsigned DEGLITCH_CYC = 8
) (
  input wire logic      i_clk,
  input wire logic      i_rst_n,
  input wire logic      i_aux_good,
  input wire logic      i_enable,
  input wire logic      i_adv_level_sel_lo,
  input wire logic      i_adv_level_sel_hi,
  input wire tsac_det_t i_det,
  input wire logic      i_load_over,
  input wire tsac_sw_t  o_sw,
  input wire tsac_adv_t o_adv,
  input wire logic      o_cc_mon_en,
  input wire logic      o_plug_orientation_flag_oe,
  input wire logic      o_test_acc_oe,
  input wire logic      o_sink_attached_n_oe,
  input wire logic      o_high_load_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic      [15:0] stab;
  logic      [15:0] next_stab;
  tsac_det_t        prev;
  logic             no_rd;

  // cycles the raw detection input has stayed unchanged
  always_comb begin
    next_stab = (i_det != prev) ? 16'h0000 :
                stab + ((stab != 16'hffff) ? 16'h0001 : 16'h0000);
    no_rd = (i_det.cc1 != TSAC_CC_RD) && (i_det.cc2 != TSAC_CC_RD);
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stab <= 16'h0000;
      prev <= TSAC_DET_RST;
    end else begin
      stab <= next_stab;
      prev <= i_det;
    end
  end

  // ==========================================================================
  // relations at the ports
  disable_off_a: assert property ((!i_enable || !i_aux_good)[*8]
    |=> !o_cc_mon_en && o_sw == TSAC_SW_OFF && !o_sink_attached_n_oe &&
    !o_test_acc_oe && !o_plug_orientation_flag_oe && !o_high_load_oe)
    else $error("disabled port not released");
  orient_sink_a: assert property (o_plug_orientation_flag_oe |->
    o_sink_attached_n_oe) else $error("orientation without sink");
  flag_excl_a: assert property (!(o_test_acc_oe &&
    (o_sink_attached_n_oe || o_plug_orientation_flag_oe)))
    else $error("conflicting attach flags");
  deglitch_hold_a: assert property ($rose(o_sw.vbus_on) |->
    32'(stab) >= DEGLITCH_CYC) else $error("vbus before deglitch");
  vbus_drop_a: assert property (no_rd[*8] |=> !o_sw.vbus_on)
    else $error("vbus kept after detach");
  adv_map_a: assert property (($stable(i_adv_level_sel_lo) &&
    $stable(i_adv_level_sel_hi))[*8] |-> o_adv == (!i_adv_level_sel_lo ?
    TSAC_ADV_STD : i_adv_level_sel_hi ? TSAC_ADV_3A : TSAC_ADV_1A5))
    else $error("advertisement mismatch");
  high_load_a: assert property ((i_load_over && o_sink_attached_n_oe)
    [*8] |-> o_high_load_oe) else $error("high load not flagged");
  load_release_a: assert property ((!i_load_over)[*8] |->
    !o_high_load_oe) else $error("high load flag held");
  acc_detach_a: assert property ((i_det.cc1 != TSAC_CC_RD)[*8] |=>
    !o_test_acc_oe) else $error("test accessory flag held");
endmodule

bind tsac_top tsac_top_monitor #(.DEGLITCH_CYC(DEGLITCH_CYC)) i_mon (.*);
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
module tb_top;
  import tsac_pkg::*;
  logic       i_clk, i_rst_n, i_aux_good, i_enable, lo, hi, i_load_over;
  logic [2:0] mode;
  tsac_det_t  i_det;
  tsac_sw_t   o_sw;
  tsac_adv_t  o_adv;
  logic       o_cc_mon_en, o_orient, o_tacc, o_sink, o_hl;
  int         mismatches, checks;

  tsac_top #(.DEGLITCH_CYC(8)) i_tsac_top (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_aux_good(i_aux_good), .i_enable(i_enable), .i_adv_level_sel_lo(lo),
    .i_adv_level_sel_hi(hi), .i_det(i_det), .i_load_over(i_load_over),
    .o_sw(o_sw), .o_adv(o_adv), .o_cc_mon_en(o_cc_mon_en),
    .o_plug_orientation_flag_oe(o_orient), .o_test_acc_oe(o_tacc),
    .o_sink_attached_n_oe(o_sink), .o_high_load_oe(o_hl));
  tsac_sink_model i_tsac_sink_model (.i_mode(mode), .o_det(i_det));

  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic flags(input logic [2:0] sw, input logic [2:0] f);
    chk("switches", {1'b0, sw}, {1'b0, o_sw});
    chk("flags", {1'b0, f}, {1'b0, o_orient, o_tacc, o_sink});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic s_sink;
    mode = 3'h1;
    w(10);
    chk("early vbus", 4'h0, {3'h0, o_sw.vbus_on});
    w(20);
    flags(3'b100, 3'b001);
    i_load_over = 1'b1;
    w(10);
    chk("high load", 4'h1, {3'h0, o_hl});
    mode = 3'h0;
    w(12);
    flags(3'b000, 3'b000);
    chk("load released", 4'h0, {3'h0, o_hl});
    i_load_over = 1'b0;
    mode = 3'h2;
    w(30);
    flags(3'b110, 3'b101);
    mode = 3'h0;
    w(12);
    mode = 3'h4;
    w(30);
    flags(3'b101, 3'b001);
    mode = 3'h0;
    w(12);
  endtask
  task automatic s_glitch;
    mode = 3'h1;
    w(6);
    mode = 3'h0;
    w(4);
    flags(3'b000, 3'b000);
    w(26);
    flags(3'b000, 3'b000);
  endtask
  task automatic s_tacc;
    mode = 3'h3;
    w(30);
    chk("acc flags", 4'h2, {1'b0, o_orient, o_tacc, o_sink});
    mode = 3'h1;
    w(20);
    chk("acc kept", 4'h2, {1'b0, o_orient, o_tacc, o_sink});
    mode = 3'h0;
    w(12);
    chk("acc gone", 4'h0, {3'h0, o_tacc});
  endtask
  task automatic s_disable;
    mode = 3'h1;
    i_load_over = 1'b1;
    w(30);
    i_enable = 1'b0;
    w(10);
    flags(3'b000, 3'b000);
    chk("monitor", 4'h0, {2'h0, o_cc_mon_en, o_hl});
    i_enable = 1'b1;
    w(30);
    flags(3'b100, 3'b001);
    chk("monitor on", 4'h3, {2'h0, o_cc_mon_en, o_hl});
    i_aux_good = 1'b0;
    w(10);
    flags(3'b000, 3'b000);
    i_aux_good = 1'b1;
    i_load_over = 1'b0;
    mode = 3'h0;
    w(20);
  endtask
  task automatic s_adv;
    for (int i = 0; i < 4; i++) begin
      {lo, hi} = 2'(i);
      w(8);
      chk("adv", !lo ? 4'h0 : hi ? 4'h2 : 4'h1, {2'h0, o_adv});
    end
  endtask

  // 125 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // main sequence; enable is always driven to a level
  initial begin
    {i_rst_n, i_aux_good, i_enable, lo, hi, i_load_over} = 6'h00;
    mode = 3'h0;
    w(12);
    i_rst_n = 1'b1;
    i_aux_good = 1'b1;
    i_enable = 1'b1;
    w(10);
    s_adv();
    s_sink();
    s_glitch();
    s_tacc();
    s_disable();
    final_report();
  end
  // watchdog
  initial begin
    #40000;
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
